/* File: sim/swap_partner_model.sv */
// Far-end port model: acknowledges Accept and PS_RDY.
// Assumes one-cycle message pulses; drives at the falling edge.
`timescale 1ns/1ps
module swap_partner_model
    import swap_seq_pkg::*;
(
    input wire logic clk,
    input wire logic [3:0] ack_dly,
    input wire logic snd_acc,
    input wire logic snd_rdy,
    input wire msg_t tx_msg,
    output msg_t rx_msg
);
    logic crc_reg = 1'b0;
    logic pend_reg = 1'b0;
    logic [3:0] cnt_reg = 4'h0;
    // Slow peer when ack_dly is nonzero
    always @(negedge clk) begin
        crc_reg <= 1'b0;
        if (!pend_reg && (tx_msg.accept || tx_msg.ps_rdy)) begin
            pend_reg <= 1'b1;
            cnt_reg <= ack_dly;
        end else if (pend_reg && cnt_reg == 4'h0) begin
            pend_reg <= 1'b0;
            crc_reg <= 1'b1;
        end else if (pend_reg) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
    assign rx_msg = '{accept: snd_acc, ps_rdy: snd_rdy, goodcrc: crc_reg};
endmodule : swap_partner_model

/* File: sim/swap_seq_checker.sv */
// Port checker for the power role swap sequencer.
// Assumes binding to the sequencer top module.
`timescale 1ns/1ps
module swap_seq_checker
    import swap_seq_pkg::*;
#(
    parameter int SINK_TRANSITION_WAIT = 1500
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic START_AS_SINK,
    input wire msg_t RX_MSG,
    input wire msg_t TX_MSG,
    input wire logic SUPPLY_STANDBY_DONE,
    input wire supply_cmd_t SUPPLY_CMD,
    input wire logic CURRENT_LIMIT_EN,
    input wire logic SOURCE_OFF_RUN,
    input wire logic SOURCE_ON_RUN,
    input wire logic READY_NEW_SINK,
    input wire logic DONE,
    input wire logic ERROR
);
    logic snk_wait_reg;
    logic acc_pend_reg;
    logic rdy_pend_reg;
    logic [19:0] cnt_reg;
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    always_ff @(posedge CLK) begin
        if (SRST || ERROR || RX_MSG.accept)
            snk_wait_reg <= 1'b0;
        else if (START_AS_SINK)
            snk_wait_reg <= 1'b1;
    end
    always_ff @(posedge CLK) begin
        if (SRST || RX_MSG.goodcrc)
            acc_pend_reg <= 1'b0;
        else if (TX_MSG.accept)
            acc_pend_reg <= 1'b1;
    end
    always_ff @(posedge CLK) begin
        if (SRST || RX_MSG.goodcrc)
            rdy_pend_reg <= 1'b0;
        else if (TX_MSG.ps_rdy && SUPPLY_CMD == SUPPLY_STANDBY)
            rdy_pend_reg <= 1'b1;
    end
    // Cycles since the Accept acknowledge
    always_ff @(posedge CLK) begin
        if (acc_pend_reg && RX_MSG.goodcrc)
            cnt_reg <= 20'h00000;
        else if (cnt_reg != 20'hFFFFF)
            cnt_reg <= cnt_reg + 20'h00001;
    end
    sequence s_ack_stby;
        TX_MSG.goodcrc ##1 (SUPPLY_CMD == SUPPLY_STANDBY
            && CURRENT_LIMIT_EN && SOURCE_OFF_RUN);
    endsequence
    sequence s_ack_sink;
        TX_MSG.goodcrc ##1 (SUPPLY_CMD == SUPPLY_SINK && DONE
            && !SOURCE_ON_RUN);
    endsequence
    a_trans_wait: assert property (
        $rose(SUPPLY_CMD == SUPPLY_STANDBY) && !CURRENT_LIMIT_EN
        |-> cnt_reg >= SINK_TRANSITION_WAIT
        && cnt_reg <= SINK_TRANSITION_WAIT + 2)
        else $error("standby wait wrong");
    a_snk_accept: assert property (
        snk_wait_reg && RX_MSG.accept |=> s_ack_stby)
        else $error("accept handling wrong");
    a_stby_limit: assert property (
        CURRENT_LIMIT_EN |-> SUPPLY_CMD == SUPPLY_STANDBY)
        else $error("limit outside standby");
    a_src_ps_rdy: assert property (
        $rose(SUPPLY_STANDBY_DONE) && SUPPLY_CMD == SUPPLY_STANDBY
        && !CURRENT_LIMIT_EN |=> TX_MSG.ps_rdy)
        else $error("no ps_rdy from source");
    a_on_start: assert property (
        rdy_pend_reg && RX_MSG.goodcrc |=> READY_NEW_SINK ##1 SOURCE_ON_RUN)
        else $error("on timer not started");
    a_off_stop: assert property (
        RX_MSG.ps_rdy && SOURCE_OFF_RUN |-> ##2 !SOURCE_OFF_RUN)
        else $error("off timer not stopped");
    a_src_after: assert property (
        $rose(SUPPLY_CMD == SUPPLY_SOURCE)
        |-> $past(TX_MSG.goodcrc) && !CURRENT_LIMIT_EN)
        else $error("source command early");
    a_new_sink: assert property (
        RX_MSG.ps_rdy && SOURCE_ON_RUN |=> s_ack_sink)
        else $error("new sink steps wrong");
    a_err_hold: assert property (
        ERROR |-> SUPPLY_CMD == SUPPLY_HOLD && !CURRENT_LIMIT_EN)
        else $error("supply not held on error");
endmodule : swap_seq_checker
bind power_role_swap_sequencer swap_seq_checker #(
    .SINK_TRANSITION_WAIT(SINK_TRANSITION_WAIT)
) swap_seq_checker_i (.CLK(CLK), .SRST(SRST),
    .START_AS_SINK(START_AS_SINK), .RX_MSG(RX_MSG), .TX_MSG(TX_MSG),
    .SUPPLY_STANDBY_DONE(SUPPLY_STANDBY_DONE), .SUPPLY_CMD(SUPPLY_CMD),
    .CURRENT_LIMIT_EN(CURRENT_LIMIT_EN), .SOURCE_OFF_RUN(SOURCE_OFF_RUN),
    .SOURCE_ON_RUN(SOURCE_ON_RUN), .READY_NEW_SINK(READY_NEW_SINK),
    .DONE(DONE), .ERROR(ERROR));

/* File: sim/test_power_role_swap_sequencer.sv */
// Self-checking bench for the swap sequencer.
// Assumes the partner model on the message link.
`timescale 1ns/1ps
module test_power_role_swap_sequencer;
    import swap_seq_pkg::*;
    localparam int W = 20;
    localparam int SS = 10;
    localparam int OFF = 200;
    localparam int SSS = 30;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic st_src = 1'b0;
    logic st_snk = 1'b0;
    logic sb_done = 1'b0;
    logic src_rdy = 1'b0;
    logic snd_acc = 1'b0;
    logic snd_rdy = 1'b0;
    logic [3:0] ack_dly = 4'h0;
    msg_t rx;
    msg_t tx;
    supply_cmd_t cmd;
    logic lim, off_run, on_run, rdy_snk, busy, done, err;
    int error_cnt = 0;
    int tests_run = 0;
    int n;
    always #10 CLK = ~CLK;
    power_role_swap_sequencer #(.SINK_TRANSITION_WAIT(W),
        .SINK_STANDBY_TIME(SS), .SOURCE_STANDBY_TIME(SSS),
        .SOURCE_OFF_TIMEOUT(OFF), .SOURCE_ON_TIMEOUT(200)
    ) power_role_swap_sequencer_i (.CLK(CLK), .SRST(SRST),
        .START_AS_SOURCE(st_src), .START_AS_SINK(st_snk), .RX_MSG(rx),
        .TX_MSG(tx), .SUPPLY_STANDBY_DONE(sb_done),
        .SUPPLY_SOURCE_READY(src_rdy), .SUPPLY_CMD(cmd),
        .CURRENT_LIMIT_EN(lim), .SOURCE_OFF_RUN(off_run),
        .SOURCE_ON_RUN(on_run), .READY_NEW_SINK(rdy_snk), .BUSY(busy),
        .DONE(done), .ERROR(err));
    swap_partner_model swap_partner_model_i (.clk(CLK), .ack_dly(ack_dly),
        .snd_acc(snd_acc), .snd_rdy(snd_rdy), .tx_msg(tx), .rx_msg(rx));
    function automatic logic sig(int k);
        case (k)
            0: return tx.accept;
            1: return tx.ps_rdy;
            3: return cmd == SUPPLY_STANDBY;
            5: return done;
            6: return err;
            default: return rdy_snk;
        endcase
    endfunction : sig
    task automatic end_of_test();
        $display("compares=%0d mismatches=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(logic [19:0] got, logic [19:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_sig(int k, int lim_c);
        n = 0;
        while (sig(k) !== 1'b1 && n < lim_c) begin
            @(negedge CLK);
            n++;
        end
        chk(20'(sig(k)), 20'h00001);
        if (sig(k) !== 1'b1) end_of_test();
    endtask : wait_sig
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge CLK);
        s = 1'b0;
    endtask : pulse
    task automatic fin(string name);
        sb_done = 1'b0;
        src_rdy = 1'b0;
        repeat (3) @(negedge CLK);
        chk(20'({busy, off_run, on_run}), 20'h00000);
        $display("done %s", name);
    endtask : fin
    task automatic t_source();
        ack_dly = 4'h3;
        pulse(st_src);
        wait_sig(0, 0);
        wait_sig(3, W + 20);
        chk(20'(n inside {[W + 3:W + 7]}), 20'h00001);
        chk(20'(busy), 20'h00001);
        sb_done = 1'b1;
        wait_sig(1, 3);
        chk(20'(n), 20'h00001);
        wait_sig(7, 8);
        @(negedge CLK);
        chk(20'(on_run), 20'h00001);
        pulse(snd_rdy);
        chk(20'(tx.goodcrc), 20'h00001);
        wait_sig(5, 2);
        chk(20'({cmd, on_run, rdy_snk}), 20'h0000C);
        fin("source");
    endtask : t_source
    task automatic t_sink();
        ack_dly = 4'h0;
        pulse(st_snk);
        pulse(snd_acc);
        chk(20'(tx.goodcrc), 20'h00001);
        @(negedge CLK);
        chk(20'({cmd, lim, off_run}), 20'h00007);
        sb_done = 1'b1;
        @(negedge CLK);
        pulse(snd_rdy);
        chk(20'(tx.goodcrc), 20'h00001);
        @(negedge CLK);
        chk(20'({cmd, lim, off_run}), 20'h00008);
        src_rdy = 1'b1;
        wait_sig(1, 3);
        chk(20'(n), 20'h00001);
        wait_sig(5, 3);
        fin("sink");
    endtask : t_sink
    task automatic t_timeout(logic stby, int exp_n);
        pulse(st_snk);
        // Late Accept must not eat into the standby time
        repeat (SS + 5) @(negedge CLK);
        pulse(snd_acc);
        sb_done = stby;
        wait_sig(6, exp_n + 20);
        chk(20'(n inside {[exp_n - 5:exp_n + 5]}), 20'h00001);
        chk(20'(cmd), 20'(SUPPLY_HOLD));
        fin("timeout");
    endtask : t_timeout
    task automatic t_src_stby();
        pulse(st_src);
        wait_sig(3, W + 20);
        wait_sig(6, SSS + 10);
        chk(20'(n inside {[SSS - 5:SSS + 5]}), 20'h00001);
        chk(20'(cmd), 20'(SUPPLY_HOLD));
        fin("source standby");
    endtask : t_src_stby
    initial begin
        repeat (4) @(negedge CLK);
        SRST = 1'b0;
        @(negedge CLK);
        t_source();
        t_sink();
        t_src_stby();
        t_timeout(1'b1, OFF);
        t_timeout(1'b0, SS);
        end_of_test();
    end
endmodule : test_power_role_swap_sequencer

/* File: verilog/power_role_swap_sequencer.sv */
// Power role swap sequencer for either the initial source or sink.
// Assumes message pulses and supply status inputs are synchronous to CLK.
`timescale 1ns/1ps
module power_role_swap_sequencer #(
    parameter int SINK_TRANSITION_WAIT =
        swap_seq_pkg::SINK_TRANSITION_WAIT_CYC,
    parameter int SINK_STANDBY_TIME = swap_seq_pkg::SINK_STANDBY_TIME_CYC,
    parameter int SOURCE_STANDBY_TIME = swap_seq_pkg::SOURCE_STANDBY_TIME_CYC,
    parameter int SOURCE_OFF_TIMEOUT = swap_seq_pkg::SOURCE_OFF_TIMER_CYC,
    parameter int SOURCE_ON_TIMEOUT = swap_seq_pkg::SOURCE_ON_TIMER_CYC
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic START_AS_SOURCE,
    input wire logic START_AS_SINK,
    input wire swap_seq_pkg::msg_t RX_MSG,
    output swap_seq_pkg::msg_t TX_MSG,
    input wire logic SUPPLY_STANDBY_DONE,
    input wire logic SUPPLY_SOURCE_READY,
    output swap_seq_pkg::supply_cmd_t SUPPLY_CMD,
    output logic CURRENT_LIMIT_EN,
    output logic SOURCE_OFF_RUN,
    output logic SOURCE_ON_RUN,
    output logic READY_NEW_SINK,
    output logic BUSY,
    output logic DONE,
    output logic ERROR
);
    import swap_seq_pkg::*;

    state_t state_reg;
    logic [CNT_W-1:0] wait_cnt_reg;
    logic [CNT_W-1:0] sup_cnt_reg;
    logic off_run_reg;
    logic on_run_reg;
    logic wait_expired;
    logic sup_expired;
    logic wait_clear;

    function automatic logic reached(input logic [CNT_W-1:0] cnt,
                                     input int limit);
        reached = (cnt >= CNT_W'(limit - 1));
    endfunction : reached

    // Step wait counter: cleared on entry to each timed step
    always_comb begin
        wait_expired = 1'b0;
        case (state_reg)
            ST_SRC_TRANS: wait_expired = reached(wait_cnt_reg,
                                                 SINK_TRANSITION_WAIT);
            ST_SRC_STBY: wait_expired = reached(wait_cnt_reg,
                                                SOURCE_STANDBY_TIME);
            ST_SNK_STBY: wait_expired = reached(wait_cnt_reg,
                                                SINK_STANDBY_TIME);
            default: wait_expired = 1'b0;
        endcase
        // Stale count from the last step ignored in its first cycle
        if (wait_clear) begin
            wait_expired = 1'b0;
        end
    end

    assign sup_expired = (off_run_reg && reached(sup_cnt_reg,
                                                 SOURCE_OFF_TIMEOUT))
                      || (on_run_reg && reached(sup_cnt_reg,
                                                SOURCE_ON_TIMEOUT));

    always_ff @(posedge CLK) begin
        if (SRST || wait_clear) begin
            wait_cnt_reg <= CNT_RESET;
        end else if (!wait_expired) begin
            wait_cnt_reg <= wait_cnt_reg + CNT_W'(1);
        end
    end

    // Supervision timers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            off_run_reg <= 1'b0;
            on_run_reg <= 1'b0;
            sup_cnt_reg <= CNT_RESET;
        end else if (sup_expired) begin
            off_run_reg <= 1'b0;
            on_run_reg <= 1'b0;
            sup_cnt_reg <= CNT_RESET;
        end else if (state_reg == ST_IDLE) begin
            // Aborted steps leave no timer running
            off_run_reg <= 1'b0;
            on_run_reg <= 1'b0;
            sup_cnt_reg <= CNT_RESET;
        end else if (state_reg == ST_SNK_WAIT_ACC && RX_MSG.accept) begin
            off_run_reg <= 1'b1;
            sup_cnt_reg <= CNT_RESET;
        end else if (off_run_reg && RX_MSG.ps_rdy &&
                     state_reg inside {ST_SNK_STBY, ST_SNK_WAIT_RDY}) begin
            off_run_reg <= 1'b0;
        end else if (state_reg == ST_SRC_RDY_CRC && RX_MSG.goodcrc) begin
            on_run_reg <= 1'b1;
            sup_cnt_reg <= CNT_RESET;
        end else if (on_run_reg && RX_MSG.ps_rdy &&
                     state_reg == ST_SRC_WAIT_RDY) begin
            on_run_reg <= 1'b0;
        end else if (off_run_reg || on_run_reg) begin
            sup_cnt_reg <= sup_cnt_reg + CNT_W'(1);
        end
    end

    // Sequence control
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_reg <= ST_IDLE;
            TX_MSG <= MSG_NONE;
            SUPPLY_CMD <= SUPPLY_HOLD;
            CURRENT_LIMIT_EN <= 1'b0;
            READY_NEW_SINK <= 1'b0;
            DONE <= 1'b0;
            ERROR <= 1'b0;
            wait_clear <= 1'b1;
        end else begin
            TX_MSG <= MSG_NONE;
            DONE <= 1'b0;
            ERROR <= 1'b0;
            wait_clear <= 1'b0;
            if (sup_expired && state_reg != ST_IDLE) begin
                state_reg <= ST_IDLE;
                SUPPLY_CMD <= SUPPLY_HOLD;
                CURRENT_LIMIT_EN <= 1'b0;
                READY_NEW_SINK <= 1'b0;
                ERROR <= 1'b1;
                wait_clear <= 1'b1;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        wait_clear <= 1'b1;
                        if (START_AS_SOURCE) begin
                            TX_MSG.accept <= 1'b1;
                            state_reg <= ST_SRC_ACC_CRC;
                        end else if (START_AS_SINK) begin
                            state_reg <= ST_SNK_WAIT_ACC;
                        end
                    end
                    ST_SRC_ACC_CRC: begin
                        wait_clear <= 1'b1;
                        if (RX_MSG.goodcrc) begin
                            state_reg <= ST_SRC_TRANS;
                        end
                    end
                    ST_SRC_TRANS: begin
                        if (wait_expired) begin
                            SUPPLY_CMD <= SUPPLY_STANDBY;
                            wait_clear <= 1'b1;
                            state_reg <= ST_SRC_STBY;
                        end
                    end
                    ST_SRC_STBY: begin
                        if (SUPPLY_STANDBY_DONE) begin
                            TX_MSG.ps_rdy <= 1'b1;
                            state_reg <= ST_SRC_RDY_CRC;
                        end else if (wait_expired) begin
                            ERROR <= 1'b1;
                            SUPPLY_CMD <= SUPPLY_HOLD;
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_SRC_RDY_CRC: begin
                        if (RX_MSG.goodcrc) begin
                            READY_NEW_SINK <= 1'b1;
                            state_reg <= ST_SRC_WAIT_RDY;
                        end
                    end
                    ST_SRC_WAIT_RDY: begin
                        if (RX_MSG.ps_rdy) begin
                            TX_MSG.goodcrc <= 1'b1;
                            state_reg <= ST_SRC_EVAL_RDY;
                        end
                    end
                    ST_SRC_EVAL_RDY: begin
                        SUPPLY_CMD <= SUPPLY_SINK;
                        READY_NEW_SINK <= 1'b0;
                        DONE <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                    ST_SNK_WAIT_ACC: begin
                        if (RX_MSG.accept) begin
                            TX_MSG.goodcrc <= 1'b1;
                            state_reg <= ST_SNK_EVAL_ACC;
                        end
                    end
                    ST_SNK_EVAL_ACC: begin
                        SUPPLY_CMD <= SUPPLY_STANDBY;
                        CURRENT_LIMIT_EN <= 1'b1;
                        wait_clear <= 1'b1;
                        state_reg <= ST_SNK_STBY;
                    end
                    ST_SNK_STBY: begin
                        if (SUPPLY_STANDBY_DONE) begin
                            state_reg <= ST_SNK_WAIT_RDY;
                        end else if (wait_expired) begin
                            ERROR <= 1'b1;
                            SUPPLY_CMD <= SUPPLY_HOLD;
                            CURRENT_LIMIT_EN <= 1'b0;
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_SNK_WAIT_RDY: begin
                        if (RX_MSG.ps_rdy) begin
                            TX_MSG.goodcrc <= 1'b1;
                            state_reg <= ST_SNK_EVAL_RDY;
                        end
                    end
                    ST_SNK_EVAL_RDY: begin
                        SUPPLY_CMD <= SUPPLY_SOURCE;
                        CURRENT_LIMIT_EN <= 1'b0;
                        state_reg <= ST_SNK_NEW_SRC;
                    end
                    ST_SNK_NEW_SRC: begin
                        if (SUPPLY_SOURCE_READY) begin
                            TX_MSG.ps_rdy <= 1'b1;
                            state_reg <= ST_SNK_RDY_CRC;
                        end
                    end
                    ST_SNK_RDY_CRC: begin
                        if (RX_MSG.goodcrc) begin
                            DONE <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            SOURCE_OFF_RUN <= 1'b0;
            SOURCE_ON_RUN <= 1'b0;
            BUSY <= 1'b0;
        end else begin
            SOURCE_OFF_RUN <= off_run_reg;
            SOURCE_ON_RUN <= on_run_reg;
            BUSY <= (state_reg != ST_IDLE);
        end
    end

endmodule : power_role_swap_sequencer

/* File: verilog/swap_seq_pkg.sv */
// Constants, types and timing for the power role swap sequencer.
// Assumes a 50 MHz clock and a message link that handles framing.
package swap_seq_pkg;

    localparam int CLK_MHZ = 50;

    // Times in microseconds
    localparam int SINK_TRANSITION_WAIT_US = 30;
    localparam int SINK_STANDBY_TIME_US = 20;
    localparam int SOURCE_STANDBY_TIME_US = 650;
    localparam int SOURCE_OFF_TIMER_US = 800;
    localparam int SOURCE_ON_TIMER_US = 400;

    // Counts in clock cycles
    localparam int SINK_TRANSITION_WAIT_CYC =
        SINK_TRANSITION_WAIT_US * CLK_MHZ;
    localparam int SINK_STANDBY_TIME_CYC = SINK_STANDBY_TIME_US * CLK_MHZ;
    localparam int SOURCE_STANDBY_TIME_CYC = SOURCE_STANDBY_TIME_US * CLK_MHZ;
    localparam int SOURCE_OFF_TIMER_CYC = SOURCE_OFF_TIMER_US * CLK_MHZ;
    localparam int SOURCE_ON_TIMER_CYC = SOURCE_ON_TIMER_US * CLK_MHZ;

    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] CNT_RESET = 20'h00000;

    typedef enum logic [1:0] {
        SUPPLY_HOLD = 2'h0,
        SUPPLY_STANDBY = 2'h1,
        SUPPLY_SOURCE = 2'h2,
        SUPPLY_SINK = 2'h3
    } supply_cmd_t;

    // One-cycle message pulses, either direction
    typedef struct packed {
        logic accept;
        logic ps_rdy;
        logic goodcrc;
    } msg_t;

    localparam msg_t MSG_NONE = 3'h0;

    typedef enum logic [13:0] {
        ST_IDLE = 14'h0001,
        ST_SRC_ACC_CRC = 14'h0002,
        ST_SRC_TRANS = 14'h0004,
        ST_SRC_STBY = 14'h0008,
        ST_SRC_RDY_CRC = 14'h0010,
        ST_SRC_WAIT_RDY = 14'h0020,
        ST_SNK_WAIT_ACC = 14'h0040,
        ST_SNK_EVAL_ACC = 14'h0080,
        ST_SNK_STBY = 14'h0100,
        ST_SNK_WAIT_RDY = 14'h0200,
        ST_SNK_EVAL_RDY = 14'h0400,
        ST_SNK_NEW_SRC = 14'h0800,
        ST_SNK_RDY_CRC = 14'h1000,
        ST_SRC_EVAL_RDY = 14'h2000
    } state_t;

endpackage : swap_seq_pkg
